// File: hdl/itac_pkg.sv
// Package for the indirect table access controller.
// Assumes an 8-bit register port with 8-bit addresses and a single core clock.
package itac_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ITAC_OFS_CTRL_HIGH   = 8'h6e;
  localparam logic [7:0] ITAC_OFS_TRIG_LOW    = 8'h6f;
  localparam logic [7:0] ITAC_OFS_DATA_FIRST  = 8'h70;
  localparam logic [7:0] ITAC_OFS_DATA_LAST   = 8'h78;
  localparam logic [7:0] ITAC_OFS_BYTE        = 8'ha0;

  // ==========================================================================
  // Field positions of the high control register
  localparam int ITAC_FUNC_MSB  = 7;
  localparam int ITAC_FUNC_LSB  = 5;
  localparam int ITAC_READ_BIT  = 4;
  localparam int ITAC_TSEL_MSB  = 3;
  localparam int ITAC_TSEL_LSB  = 2;
  localparam int ITAC_AHI_MSB   = 1;
  localparam int ITAC_AHI_LSB   = 0;

  // ==========================================================================
  // Reset values and data byte count
  localparam logic [7:0] ITAC_CTRL_RESET = 8'h00;
  localparam logic [7:0] ITAC_TRIG_RESET = 8'h00;
  localparam int         ITAC_DATA_BYTES = 9;

  // ==========================================================================
  // Function select codes
  localparam logic [2:0] ITAC_FUNC_TABLE = 3'h0;
  localparam logic [2:0] ITAC_FUNC_EEE   = 3'h1;
  localparam logic [2:0] ITAC_FUNC_ACL   = 3'h2;
  localparam logic [2:0] ITAC_FUNC_RSVD  = 3'h3;
  localparam logic [2:0] ITAC_FUNC_PME   = 3'h4;
  localparam logic [2:0] ITAC_FUNC_CABLE = 3'h5;

  // Port field codes
  localparam logic [3:0] ITAC_PORT_GLOBAL = 4'h0;
  localparam logic [3:0] ITAC_PORT_1      = 4'h1;
  localparam logic [3:0] ITAC_PORT_2      = 4'h2;
  localparam logic [3:0] ITAC_PORT_4      = 4'h5;
  localparam logic [3:0] ITAC_PORT_RSVD   = 4'h6;

  // Targets of a launched command
  typedef enum logic [3:0] {
    ITAC_TGT_STATIC,
    ITAC_TGT_VLAN,
    ITAC_TGT_DYNAMIC,
    ITAC_TGT_MIB,
    ITAC_TGT_EEE,
    ITAC_TGT_ACL,
    ITAC_TGT_PME,
    ITAC_TGT_CABLE,
    ITAC_TGT_NONE
  } itac_target_t;

endpackage : itac_pkg

// File: hdl/itac_decode.sv
// Decoder of the high control register into target, address and port.
// Assumes a registered control byte on the same clock; purely combinational.
`timescale 1ns/10ps
module itac_decode (
  // Control byte
  input  wire logic [7:0]          ctrl_i,
  // Decoded command
  output itac_pkg::itac_target_t   target_o,
  output logic      [11:8]         addr_hi_o,
  output logic      [3:0]          port_o,
  output logic                     port_valid_o,
  output logic                     read_o
);

  logic [2:0] func;
  logic [1:0] tsel;

  assign func = ctrl_i[itac_pkg::ITAC_FUNC_MSB:itac_pkg::ITAC_FUNC_LSB];
  assign tsel = ctrl_i[itac_pkg::ITAC_TSEL_MSB:itac_pkg::ITAC_TSEL_LSB];

  // ==========================================================================
  // Direction and address bits
  // read when set
  assign read_o = ctrl_i[itac_pkg::ITAC_READ_BIT];
  assign addr_hi_o = (func == itac_pkg::ITAC_FUNC_TABLE) ? {2'h0, ctrl_i[1:0]} : ctrl_i[3:0];
  assign port_o    = ctrl_i[3:0];

  always_comb begin
    unique case (ctrl_i[3:0])
      itac_pkg::ITAC_PORT_GLOBAL,
      itac_pkg::ITAC_PORT_1,
      itac_pkg::ITAC_PORT_2,
      itac_pkg::ITAC_PORT_4: port_valid_o = (func != itac_pkg::ITAC_FUNC_TABLE);
      default:               port_valid_o = 1'b0;
    endcase
  end

  // ==========================================================================
  // Target selection by function code
  always_comb begin
    target_o = itac_pkg::ITAC_TGT_NONE;
    unique case (func)
      itac_pkg::ITAC_FUNC_TABLE: begin
        unique case (tsel)
          2'h0: target_o = itac_pkg::ITAC_TGT_STATIC;
          2'h1: target_o = itac_pkg::ITAC_TGT_VLAN;
          2'h2: target_o = itac_pkg::ITAC_TGT_DYNAMIC;
          2'h3: target_o = itac_pkg::ITAC_TGT_MIB;
        endcase
      end
      itac_pkg::ITAC_FUNC_EEE:   target_o = itac_pkg::ITAC_TGT_EEE;
      itac_pkg::ITAC_FUNC_ACL:   target_o = itac_pkg::ITAC_TGT_ACL;
      itac_pkg::ITAC_FUNC_PME:   target_o = itac_pkg::ITAC_TGT_PME;
      itac_pkg::ITAC_FUNC_CABLE: target_o = itac_pkg::ITAC_TGT_CABLE;
      default:                   target_o = itac_pkg::ITAC_TGT_NONE;
    endcase
  end

endmodule : itac_decode

// File: hdl/itac_top.sv
// Indirect table access controller: two control registers that launch commands.
// Assumes an 8-bit register port on the core clock, and table logic that
// answers a launched command with a one-cycle done pulse.
`timescale 1ns/10ps
module itac_top (
  // Clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       reset_i,
  // Register port
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  output logic      [7:0]                 reg_rdata_o,
  // Command to table logic
  output logic                            cmd_start_o,
  output itac_pkg::itac_target_t          cmd_target_o,
  output logic                            cmd_read_o,
  output logic      [11:0]                cmd_addr_o,
  output logic      [3:0]                 cmd_port_o,
  output logic                            cmd_port_valid_o,
  output logic      [71:0]                cmd_wdata_o,
  output logic                            cmd_busy_o,
  // Answer from table logic
  input  wire logic                       cmd_done_i,
  input  wire logic [71:0]                cmd_rdata_i
);

  logic [7:0]              ctrl_q;
  logic [7:0]              trig_q;
  logic [71:0]             data_q;
  logic                    start_q;
  logic                    busy_q;
  itac_pkg::itac_target_t  tgt_d;
  itac_pkg::itac_target_t  tgt_q;
  logic [11:8]             ahi_d;
  logic [3:0]              port_d;
  logic                    pvalid_d;
  logic                    read_d;
  logic                    rd_q;
  logic                    pvalid_q;
  logic [11:0]             addr_q;
  logic [3:0]              port_q;

  // ==========================================================================
  // Data byte index of an offset, zero for the top byte
  function automatic logic [3:0] itac_byte_idx(input logic [7:0] ofs);
    logic [7:0] diff;
    diff = ofs - itac_pkg::ITAC_OFS_DATA_FIRST;
    itac_byte_idx = diff[3:0];
  endfunction : itac_byte_idx

  function automatic logic itac_is_data(input logic [7:0] ofs);
    itac_is_data = (ofs >= itac_pkg::ITAC_OFS_DATA_FIRST) && (ofs <= itac_pkg::ITAC_OFS_DATA_LAST);
  endfunction : itac_is_data

  // Lane of the payload word for an index
  function automatic logic [7:0] itac_lane(input logic [71:0] w, input logic [3:0] idx);
    logic [6:0] lo;
    lo = 7'(8 * (8 - 32'(idx)));
    itac_lane = w[lo +: 8];
  endfunction : itac_lane

  // ==========================================================================
  // Decoder of the control byte
  itac_decode u_decode (
    .ctrl_i       (ctrl_q),
    .target_o     (tgt_d),
    .addr_hi_o    (ahi_d),
    .port_o       (port_d),
    .port_valid_o (pvalid_d),
    .read_o       (read_d)
  );

  // ==========================================================================
  // Control register
  // control reset zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= itac_pkg::ITAC_CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == itac_pkg::ITAC_OFS_CTRL_HIGH) begin
      ctrl_q <= reg_wdata_i;
    end
  end

  // Trigger register holds the low address byte
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      trig_q <= itac_pkg::ITAC_TRIG_RESET;
    end else if (reg_wr_i && reg_addr_i == itac_pkg::ITAC_OFS_TRIG_LOW) begin
      trig_q <= reg_wdata_i;
    end
  end

  // ==========================================================================
  // Launch on trigger write, latched command fields
  // trigger write launches
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      start_q  <= 1'b0;
      tgt_q    <= itac_pkg::ITAC_TGT_STATIC;
      rd_q     <= 1'b0;
      addr_q   <= 12'h000;
      port_q   <= 4'h0;
      pvalid_q <= 1'b0;
    end else begin
      start_q <= reg_wr_i && reg_addr_i == itac_pkg::ITAC_OFS_TRIG_LOW;
      if (reg_wr_i && reg_addr_i == itac_pkg::ITAC_OFS_TRIG_LOW) begin
        tgt_q    <= tgt_d;
        rd_q     <= read_d;
        addr_q   <= {ahi_d, reg_wdata_i};
        port_q   <= port_d;
        pvalid_q <= pvalid_d;
      end
    end
  end

  // Busy from launch until done
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
    end else if (start_q) begin
      busy_q <= 1'b1;
    end else if (cmd_done_i) begin
      busy_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Payload word, byte register in the low lane
  // nine data bytes
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      data_q <= 72'h00_0000_0000_0000_0000;
    end else if (busy_q && cmd_done_i && rd_q) begin
      data_q <= cmd_rdata_i;
    end else if (reg_wr_i && itac_is_data(reg_addr_i)) begin
      data_q[7'(8 * (8 - 32'(itac_byte_idx(reg_addr_i)))) +: 8] <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == itac_pkg::ITAC_OFS_BYTE) begin
      data_q[7:0] <= reg_wdata_i;
    end
  end

  // ==========================================================================
  // Read data, registered; unmapped offsets read zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == itac_pkg::ITAC_OFS_CTRL_HIGH) begin
        reg_rdata_o <= ctrl_q;
      end else if (reg_addr_i == itac_pkg::ITAC_OFS_TRIG_LOW) begin
        reg_rdata_o <= trig_q;
      end else if (itac_is_data(reg_addr_i)) begin
        reg_rdata_o <= itac_lane(data_q, itac_byte_idx(reg_addr_i));
      end else if (reg_addr_i == itac_pkg::ITAC_OFS_BYTE) begin
        reg_rdata_o <= data_q[7:0];
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign cmd_start_o      = start_q;
  assign cmd_target_o     = tgt_q;
  assign cmd_read_o       = rd_q;
  assign cmd_addr_o       = addr_q;
  assign cmd_port_o       = port_q;
  assign cmd_port_valid_o = pvalid_q;
  assign cmd_wdata_o      = data_q;
  assign cmd_busy_o       = busy_q;

  // ==========================================================================
  // Assertions
  AST_LAUNCH_ONE_CYCLE: assert property (@(posedge mclk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == itac_pkg::ITAC_OFS_TRIG_LOW) |=> cmd_start_o)
    else $error("Trigger write did not launch");

  AST_NO_SPURIOUS: assert property (@(posedge mclk_i) disable iff (reset_i)
    cmd_start_o |-> $past(reg_wr_i) && $past(reg_addr_i) == itac_pkg::ITAC_OFS_TRIG_LOW)
    else $error("Launch without trigger write");

  AST_DIRECTION: assert property (@(posedge mclk_i) disable iff (reset_i)
    cmd_start_o |-> cmd_read_o == $past(ctrl_q[4]))
    else $error("Direction does not follow bit four");

  AST_TABLE_SEL: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cmd_start_o && $past(ctrl_q[7:5]) == 3'h0) |-> cmd_target_o == itac_pkg::itac_target_t'($past(ctrl_q[3:2])))
    else $error("Table select wrong");

  AST_TABLE_ADDR: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cmd_start_o && $past(ctrl_q[7:5]) == 3'h0) |-> cmd_addr_o[11:10] == 2'h0)
    else $error("Table bits leaked into address");

  AST_HIGH_ADDR: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cmd_start_o && $past(ctrl_q[7:5]) != 3'h0) |-> cmd_addr_o[11:8] == $past(ctrl_q[3:0]))
    else $error("High address bits wrong");

  AST_ADDR_98: assert property (@(posedge mclk_i) disable iff (reset_i)
    cmd_start_o |-> cmd_addr_o[9:8] == $past(ctrl_q[1:0]) && cmd_addr_o[7:0] == $past(reg_wdata_i))
    else $error("Address bits nine to zero wrong");

  AST_EEE: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cmd_start_o && $past(ctrl_q[7:5]) == 3'h1) |-> cmd_target_o == itac_pkg::ITAC_TGT_EEE)
    else $error("Energy target wrong");

  AST_ACL: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cmd_start_o && $past(ctrl_q[7:5]) == 3'h2) |-> cmd_target_o == itac_pkg::ITAC_TGT_ACL)
    else $error("Access list target wrong");

  AST_PME_CABLE: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cmd_start_o && $past(ctrl_q[7:6]) == 2'h2) |->
      cmd_target_o == ($past(ctrl_q[5]) ? itac_pkg::ITAC_TGT_CABLE : itac_pkg::ITAC_TGT_PME))
    else $error("Power event or cable target wrong");

  AST_PORT_RSVD: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cmd_start_o && cmd_port_o == itac_pkg::ITAC_PORT_RSVD) |-> !cmd_port_valid_o)
    else $error("Reserved port marked valid");

  AST_READ_FILL: assert property (@(posedge mclk_i) disable iff (reset_i)
    (busy_q && cmd_done_i && rd_q) |=> cmd_wdata_o == $past(cmd_rdata_i) && cmd_busy_o == $past(start_q))
    else $error("Read answer not stored");

endmodule : itac_top

// File: bench/itac_table_model.sv
// Table logic stand-in that answers launched commands with a done pulse.
// Assumes start and address come from the controller on the same clock.
`timescale 1ns/10ps
module itac_table_model (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Command in
  input  wire logic        cmd_start_i,
  input  wire logic [11:0] cmd_addr_i,
  input  wire logic [3:0]  lat_i,
  // Answer out
  output logic             cmd_done_o,
  output logic      [71:0] cmd_rdata_o
);
  logic [3:0] cnt_q;

  // ==========================================================================
  // Latency count, done after lat_i cycles
  // device fills data
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q      <= 4'h0;
      cmd_done_o <= 1'b0;
    end else begin
      cmd_done_o <= (cnt_q == 4'h1);
      if (cmd_start_i) begin
        cnt_q <= lat_i;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // Result valid only with done, inverted otherwise
  assign cmd_rdata_o = cmd_done_o ? {6{cmd_addr_i}} : ~{6{cmd_addr_i}};
endmodule : itac_table_model

// File: bench/tb_top.sv
// Self-checking bench for the indirect table access controller.
// Assumes the table model answers every launched command after lat cycles.
`timescale 1ns/10ps
module tb_top;
  // Register port
  logic                   mclk_i      = 1'b0;
  logic                   reset_i     = 1'b1;
  logic                   reg_wr_i    = 1'b0;
  logic                   reg_rd_i    = 1'b0;
  logic [7:0]             reg_addr_i  = 8'h00;
  logic [7:0]             reg_wdata_i = 8'h00;
  logic [7:0]             reg_rdata_o;
  // Command side
  logic                   cmd_start_o, cmd_read_o, cmd_port_valid_o, cmd_busy_o, cmd_done_i;
  itac_pkg::itac_target_t cmd_target_o;
  logic [11:0]            cmd_addr_o;
  logic [3:0]             cmd_port_o;
  logic [3:0]             lat = 4'h1;
  logic [71:0]            cmd_wdata_o, cmd_rdata_i;
  int                     failures = 0;
  int                     compares = 0;
  int                     cycles = 0;

  itac_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cmd_start_o(cmd_start_o), .cmd_target_o(cmd_target_o), .cmd_read_o(cmd_read_o),
    .cmd_addr_o(cmd_addr_o), .cmd_port_o(cmd_port_o), .cmd_port_valid_o(cmd_port_valid_o),
    .cmd_wdata_o(cmd_wdata_o), .cmd_busy_o(cmd_busy_o), .cmd_done_i(cmd_done_i),
    .cmd_rdata_i(cmd_rdata_i));
  itac_table_model model (.mclk_i(mclk_i), .reset_i(reset_i), .cmd_start_i(cmd_start_o),
    .cmd_addr_i(cmd_addr_o), .lat_i(lat), .cmd_done_o(cmd_done_i), .cmd_rdata_o(cmd_rdata_i));

  // ==========================================================================
  // Clock and hang guard
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic print_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    d        = reg_rdata_o;
  endtask : rd
  task automatic launch(input logic [7:0] c, input logic [7:0] t);
    wr(itac_pkg::ITAC_OFS_CTRL_HIGH, c);
    wr(itac_pkg::ITAC_OFS_TRIG_LOW, t);
    chk({71'h0, cmd_start_o}, 72'h1);
  endtask : launch
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge mclk_i);
    chk({71'h0, cmd_start_o}, 72'h0);
    chk({71'h0, cmd_busy_o}, 72'h1);
    while (cmd_busy_o === 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    chk({71'h0, cmd_busy_o}, 72'h0);
  endtask : wait_idle

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] d;
    rd(itac_pkg::ITAC_OFS_CTRL_HIGH, d);
    chk({64'h0, d}, {64'h0, itac_pkg::ITAC_CTRL_RESET});
    chk({68'h0, cmd_target_o}, {68'h0, itac_pkg::ITAC_TGT_STATIC});
    chk({59'h0, cmd_read_o, cmd_addr_o}, 72'h0);
    chk({65'h0, cmd_start_o, cmd_busy_o, cmd_port_valid_o, cmd_port_o}, 72'h0);
    chk(cmd_wdata_o, 72'h0);
  endtask : t_reset
  task automatic t_tables;
    logic [7:0] c;
    for (int t = 0; t < 4; t++) begin
      c = {3'h0, t[0], t[1:0], t[1:0]};
      launch(c, 8'h3c);
      chk({68'h0, cmd_target_o}, {70'h0, t[1:0]});
      chk({60'h0, cmd_addr_o}, {62'h0, t[1:0], 8'h3c});
      chk({71'h0, cmd_read_o}, {71'h0, t[0]});
      wait_idle();
    end
  endtask : t_tables
  task automatic t_funcs;
    itac_pkg::itac_target_t tg [7] = '{itac_pkg::ITAC_TGT_EEE, itac_pkg::ITAC_TGT_ACL,
      itac_pkg::ITAC_TGT_NONE, itac_pkg::ITAC_TGT_PME, itac_pkg::ITAC_TGT_CABLE,
      itac_pkg::ITAC_TGT_NONE, itac_pkg::ITAC_TGT_NONE};
    logic [3:0] pc [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
    for (int f = 1; f < 8; f++) begin
      if (f == 3) begin
        continue;
      end
      launch({f[2:0], 5'h09}, 8'h5a);
      chk({68'h0, cmd_target_o}, {68'h0, tg[f-1]});
      chk({60'h0, cmd_addr_o}, 72'h95a);
      wait_idle();
    end
    for (int i = 0; i < 5; i++) begin
      launch({4'h3, pc[i]}, 8'h01);
      chk({68'h0, cmd_port_o}, {68'h0, pc[i]});
      chk({71'h0, cmd_port_valid_o}, {71'h0, pc[i] != 4'h6});
      wait_idle();
    end
  endtask : t_funcs
  task automatic t_read_fill;
    logic [7:0]  d;
    logic [71:0] e;
    e   = {6{12'h3c7}};
    lat = 4'h6;
    launch(8'h13, 8'hc7);
    wait_idle();
    for (int i = 0; i < 9; i++) begin
      rd(itac_pkg::ITAC_OFS_DATA_FIRST + 8'(i), d);
      chk({64'h0, d}, {64'h0, e[71-8*i -: 8]});
    end
    rd(itac_pkg::ITAC_OFS_BYTE, d);
    chk({64'h0, d}, {64'h0, e[7:0]});
    rd(itac_pkg::ITAC_OFS_TRIG_LOW, d);
    chk({64'h0, d}, 72'hc7);
    lat = 4'h1;
  endtask : t_read_fill
  task automatic t_write_data;
    logic [71:0] w;
    for (int i = 0; i < 9; i++) begin
      w[71-8*i -: 8] = 8'h11 * 8'(i + 1);
      wr(itac_pkg::ITAC_OFS_DATA_FIRST + 8'(i), w[71-8*i -: 8]);
    end
    wr(itac_pkg::ITAC_OFS_BYTE, 8'hee);
    w[7:0] = 8'hee;
    launch(8'h0c, 8'h00);
    chk(cmd_wdata_o, w);
    chk({71'h0, cmd_read_o}, 72'h0);
    wait_idle();
  endtask : t_write_data
  task automatic t_misc;
    logic [7:0] d;
    rd(8'h55, d);
    chk({64'h0, d}, 72'h0);
    wr(itac_pkg::ITAC_OFS_CTRL_HIGH, 8'h10);
    chk({71'h0, cmd_start_o}, 72'h0);
    rd(itac_pkg::ITAC_OFS_CTRL_HIGH, d);
    chk({64'h0, d}, 72'h10);
  endtask : t_misc

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge mclk_i);
    reset_i = 1'b0;
    t_reset();
    t_tables();
    t_funcs();
    t_read_fill();
    t_write_data();
    t_misc();
    print_verdict();
  end
endmodule : tb_top
